// ==== rtl/evt_irq_pkg.sv ====
// Package: register map, event and status layout for the event/interrupt block
package evt_irq_pkg;

    localparam int NUM_EVENTS = 27;
    localparam int NUM_STATUS = 15;

    // Register byte offsets
    localparam logic [7:0] OFF_NEW_EVENT = 8'h00;
    localparam logic [7:0] OFF_SNAP_EVENT = 8'h04;
    localparam logic [7:0] OFF_EVENT = 8'h08;
    localparam logic [7:0] OFF_EVENT_ENABLE = 8'h0C;
    localparam logic [7:0] OFF_INT_STATUS = 8'h10;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h14;
    localparam logic [7:0] OFF_INT_SET = 8'h18;

    // Reset values
    localparam logic [NUM_EVENTS-1:0] EVENT_ENABLE_RST = 27'h7FFFFFF;
    localparam logic [NUM_STATUS-1:0] INT_ENABLE_RST = 15'h0000;

    // Event bit positions
    localparam int EV_OUT_MAILBOX_READ = 0;
    localparam int EV_IN_MAILBOX_WRITE = 1;
    localparam int EV_BOOT_TIMEOUT = 2;
    localparam int EV_BOOT_PROTOCOL_ERROR = 3;
    localparam int EV_BOOT_SIZE_ERROR = 4;
    localparam int EV_BOOT_NO_DEVICE = 5;
    localparam int EV_BOOT_SUCCESS = 6;
    localparam int EV_SLAVE_COLLISION = 7;
    localparam int EV_SLAVE_TRANSACTION_TIMEOUT = 8;
    localparam int EV_SLAVE_BYTE_TIMEOUT = 9;
    localparam int EV_SLAVE_CLOCK_LOW_TIMEOUT = 10;
    localparam int EV_SLAVE_REG_WRITE_DONE = 11;
    localparam int EV_SLAVE_REG_READ_DONE = 12;
    localparam int EV_SLAVE_TRANSFER_DONE = 13;
    localparam int EV_DIAG_TIMER_EXPIRED = 14;
    localparam int EV_DIAG_HISTORY_FILLING = 15;
    localparam int EV_DIAG_COMMAND_DONE = 16;
    localparam int EV_MASTER_COLLISION = 17;
    localparam int EV_MASTER_TRANSACTION_TIMEOUT = 18;
    localparam int EV_MASTER_BYTE_TIMEOUT = 19;
    localparam int EV_MASTER_CLOCK_LOW_TIMEOUT = 20;
    localparam int EV_MASTER_NACK = 21;
    localparam int EV_MASTER_ARBITRATION_TIMEOUT = 22;
    localparam int EV_MASTER_TRANSFER_DONE = 23;

    // Status bit positions
    localparam int ST_OUT_MAILBOX_EMPTY = 0;
    localparam int ST_IN_MAILBOX_FULL = 1;
    localparam int ST_BOOT_FAIL = 2;
    localparam int ST_BOOT_SUCCESS = 3;
    localparam int ST_SLAVE_FAIL = 4;
    localparam int ST_SLAVE_WRITE = 5;
    localparam int ST_SLAVE_READ = 6;
    localparam int ST_SLAVE_SUCCESS = 7;
    localparam int ST_MASTER_DIAGNOSTIC = 8;
    localparam int ST_MASTER_COLLISION = 9;
    localparam int ST_MASTER_TIMEOUT = 10;
    localparam int ST_MASTER_NACK = 11;
    localparam int ST_MASTER_ARBITRATION_TIMEOUT = 12;
    localparam int ST_MASTER_SUCCESS = 13;

    // Status-to-event map, one event mask per status bit
    typedef logic [NUM_EVENTS-1:0] event_vec_t;
    typedef logic [NUM_STATUS-1:0] status_vec_t;

    localparam event_vec_t STATUS_MAP [NUM_STATUS] = '{
        27'h0000001, // out mailbox empty
        27'h0000002, // in mailbox full
        27'h000003C, // boot fail
        27'h0000040, // boot success
        27'h0000780, // slave fail
        27'h0000800, // slave write
        27'h0001000, // slave read
        27'h0002000, // slave success
        27'h001C000, // master diagnostic
        27'h0020000, // master collision
        27'h01C0000, // master timeout
        27'h0200000, // master nack
        27'h0400000, // master arbitration timeout
        27'h0800000, // master success
        27'h0000000  // spare
    };

    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } rd_resp_s;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== rtl/serial_bus_event_irq_logic.sv ====
// Event capture, snapshot, status aggregation and interrupt output with AXI4-Lite slave
//
// Notes on behaviour
// - Logic event or software write sets new-event
// - Virtual event reads new-event OR snapshot
// - Status read moves new-events into snapshot
// - Enabled events OR into their status bit
// - Enabled status bits OR into one interrupt
// - Status write-1 clears mapped enabled snapshot bits
// - Status clear leaves new-event bits alone
// - Snapshot readable, write-1 clears snapshot bits
// - New-event readable, write loads the written lanes: ones set, zeros clear
// - Virtual event write-1 clears both registers
// - Set wins over a simultaneous clear
// - Event enables all set after reset
// - Mailbox statuses come from single mailbox events
// - Boot fail combines four boot error events
// - Boot success status from boot success event
// - Slave fail combines four slave error events
// - Slave write, read, success single events
// - Master diagnostic combines three diagnostic events
// - Master collision single; timeout combines three
// - Nack, arbitration timeout, success single events
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps

module serial_bus_event_irq_logic
    import evt_irq_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [NUM_EVENTS-1:0] event_pulse,
    output logic irq,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // Decoder reads address bits 7:2, so narrower buses cannot reach the map
    if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_addr_width
        $error("ADDR_WIDTH must be 8 to 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage

    event_vec_t new_event_q;
    event_vec_t snap_event_q;
    event_vec_t event_enable_q;
    status_vec_t int_enable_q;
    event_vec_t virt_event;
    event_vec_t gated_event;
    status_vec_t int_status;

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data latched in either order

    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_WIDTH-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_fire;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    // Byte-enabled write data; unwritten lanes act as zeros, so they neither set nor clear
    logic [31:0] wmask;
    logic [31:0] wlanes;
    logic [7:0] wr_off;
    logic wr_known;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = w_strb_q[b] ? w_data_q[b*8 +: 8] : 8'h00;
            wlanes[b*8 +: 8] = {8{w_strb_q[b]}};
        end
        wr_off = {aw_addr_q[7:2], 2'b00};
        case (wr_off)
            OFF_NEW_EVENT, OFF_SNAP_EVENT, OFF_EVENT, OFF_EVENT_ENABLE,
            OFF_INT_STATUS, OFF_INT_ENABLE, OFF_INT_SET: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
        if (ADDR_WIDTH > 8 && (aw_addr_q >> 8) != '0) begin
            wr_known = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    logic wr_new;
    logic wr_snap;
    logic wr_virt;
    logic wr_status;
    logic wr_set;
    event_vec_t wr_ev_bits;
    event_vec_t wr_ev_lanes;
    event_vec_t virt_clr;
    status_vec_t wr_st_bits;

    assign wr_new = wr_fire && wr_known && wr_off == OFF_NEW_EVENT;
    assign wr_snap = wr_fire && wr_known && wr_off == OFF_SNAP_EVENT;
    assign wr_virt = wr_fire && wr_known && wr_off == OFF_EVENT;
    assign wr_status = wr_fire && wr_known && wr_off == OFF_INT_STATUS;
    assign wr_set = wr_fire && wr_known && wr_off == OFF_INT_SET;
    assign wr_ev_bits = wmask[NUM_EVENTS-1:0];
    assign wr_ev_lanes = wlanes[NUM_EVENTS-1:0];
    assign virt_clr = wr_virt ? wr_ev_bits : '0;
    assign wr_st_bits = wmask[NUM_STATUS-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Read channel

    logic rvalid_q;
    rd_resp_s rd_q;
    logic rd_fire;
    logic rd_status;
    rd_resp_s rd_d;

    assign s_axi_arready = !rvalid_q;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rd_q.data;
    assign s_axi_rresp = rd_q.resp;

    always_comb begin
        rd_d.data = 32'h00000000;
        rd_d.resp = RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
            OFF_NEW_EVENT: rd_d.data[NUM_EVENTS-1:0] = new_event_q;
            OFF_SNAP_EVENT: rd_d.data[NUM_EVENTS-1:0] = snap_event_q;
            OFF_EVENT: rd_d.data[NUM_EVENTS-1:0] = virt_event;
            OFF_EVENT_ENABLE: rd_d.data[NUM_EVENTS-1:0] = event_enable_q;
            OFF_INT_STATUS: rd_d.data[NUM_STATUS-1:0] = int_status;
            OFF_INT_ENABLE: rd_d.data[NUM_STATUS-1:0] = int_enable_q;
            OFF_INT_SET: rd_d.data = 32'h00000000;
            default: rd_d.resp = RESP_SLVERR;
        endcase
        if (ADDR_WIDTH > 8 && (s_axi_araddr >> 8) != '0) begin
            rd_d.data = 32'h00000000;
            rd_d.resp = RESP_SLVERR;
        end
    end

    assign rd_status = rd_fire && rd_d.resp == RESP_OKAY
        && {s_axi_araddr[7:2], 2'b00} == OFF_INT_STATUS;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rd_q <= '0;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rd_q <= rd_d;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event logic

    // Status bits expanded into the events they own; only the clear mask is restricted to enabled events
    event_vec_t set_from_status;
    event_vec_t clr_from_status;

    always_comb begin
        set_from_status = '0;
        clr_from_status = '0;
        for (int s = 0; s < NUM_STATUS; s++) begin
            if (wr_st_bits[s]) begin
                set_from_status = set_from_status | STATUS_MAP[s];
                clr_from_status = clr_from_status | (STATUS_MAP[s] & event_enable_q);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            event_enable_q <= EVENT_ENABLE_RST;
            int_enable_q <= INT_ENABLE_RST;
        end else if (wr_fire && wr_known) begin
            if (wr_off == OFF_EVENT_ENABLE) begin
                event_enable_q <= w_data_q[NUM_EVENTS-1:0];
            end
            if (wr_off == OFF_INT_ENABLE) begin
                int_enable_q <= w_data_q[NUM_STATUS-1:0];
            end
        end
    end

    // New-event register: clears first, sets last so a set always wins
    event_vec_t new_event_d;

    always_comb begin
        new_event_d = new_event_q;
        if (rd_status) begin
            new_event_d = '0;
        end
        if (wr_virt) begin
            new_event_d = new_event_d & ~wr_ev_bits;
        end
        if (wr_new) begin
            new_event_d = (new_event_d & ~wr_ev_lanes) | wr_ev_bits;
        end
        if (wr_set) begin
            new_event_d = new_event_d | set_from_status;
        end
        new_event_d = new_event_d | event_pulse;
    end

    // New-event write loads the written lanes: ones set, zeros clear

    event_vec_t snap_event_d;

    // Clears first, copy last: a read racing a clear must not drop newer events
    always_comb begin
        snap_event_d = snap_event_q;
        if (wr_status) begin
            snap_event_d = snap_event_d & ~clr_from_status;
        end
        if (wr_snap || wr_virt) begin
            snap_event_d = snap_event_d & ~wr_ev_bits;
        end
        if (rd_status) begin
            snap_event_d = snap_event_d | (new_event_q & ~virt_clr);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            new_event_q <= '0;
            snap_event_q <= '0;
        end else begin
            new_event_q <= new_event_d;
            snap_event_q <= snap_event_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status aggregation and interrupt

    assign virt_event = new_event_q | snap_event_q;
    assign gated_event = virt_event & event_enable_q;

    always_comb begin
        for (int s = 0; s < NUM_STATUS; s++) begin
            // Map fixes which events feed each status bit
            int_status[s] = |(gated_event & STATUS_MAP[s]);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_enable_q);
        end
    end

endmodule // serial_bus_event_irq_logic

// ==== bench/irq_ctrl_model.sv ====
// Interrupt controller stand-in: counts rising edges of the irq line
`timescale 1ns/1ps

module irq_ctrl_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic irq,
    output logic [7:0] irq_rises
);
    logic irq_q;

    // Level input, so only new assertions are counted
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            irq_rises <= 8'h00;
        end else begin
            irq_q <= irq;
            if (irq && !irq_q) begin
                irq_rises <= irq_rises + 8'h01;
            end
        end
    end
endmodule // irq_ctrl_model

// ==== bench/serial_bus_event_irq_logic_checker.sv ====
// Port-level assertions for the event/interrupt block
`timescale 1ns/1ps

module serial_bus_event_irq_logic_checker
    import evt_irq_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic irq,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_IRQ_QUIET_AFTER_RESET: assert property ($rose(rst_n) |-> !irq)
        else $error("irq high right after reset");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
    AST_NO_READ_WHILE_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready while read pending");
    AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped before bready");
    AST_BAD_READ: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    AST_GOOD_READ: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= 8'h18
        && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == RESP_OKAY)
        else $error("mapped read refused");
    AST_BAD_WRITE: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr > 8'h18 |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
        else $error("unmapped write not refused");
endmodule // serial_bus_event_irq_logic_checker

// ==== bench/test_serial_bus_event_irq_logic.sv ====
// Register-level tests of the event/interrupt block
`timescale 1ns/1ps

module test_serial_bus_event_irq_logic;
    import evt_irq_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, irq;
    logic [NUM_EVENTS-1:0] event_pulse = '0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, irq_rises, rises0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int fails = 0, cmp_count = 0;
    // Status bit fed by each event
    int st_of [24] = '{0, 1, 2, 2, 2, 2, 3, 4, 4, 4, 4, 5, 6, 7, 8, 8, 8, 9, 10, 10, 10, 11, 12, 13};

    serial_bus_event_irq_logic u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .event_pulse(event_pulse),
        .irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    irq_ctrl_model u_ic (.sys_clk(sys_clk), .rst_n(rst_n), .irq(irq), .irq_rises(irq_rises));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Address and data offered together; design takes both at one edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge sys_clk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk("read data", e, d);
        chk("read resp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask
    task automatic ev(input int i);
        @(posedge sys_clk);
        event_pulse[i] <= 1'b1;
        @(posedge sys_clk);
        event_pulse <= '0;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rc(OFF_EVENT_ENABLE, 32'h07FFFFFF);
        rc(OFF_INT_ENABLE, 32'h0);
        rc(OFF_NEW_EVENT, 32'h0);
        $display("reset test done");
        ev(3);
        rc(OFF_NEW_EVENT, 32'h8);
        rc(OFF_EVENT, 32'h8);
        rc(OFF_INT_STATUS, 32'h4);
        rc(OFF_NEW_EVENT, 32'h0);
        rc(OFF_SNAP_EVENT, 32'h8);
        $display("snapshot test done");
        rises0 = irq_rises;
        wr(OFF_INT_ENABLE, 32'h4);
        chk("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
        repeat (2) @(posedge sys_clk);
        chk("irq on", 32'h1, {31'h0, irq});
        ev(4);
        wr(OFF_INT_STATUS, 32'h4);
        rc(OFF_SNAP_EVENT, 32'h0);
        rc(OFF_NEW_EVENT, 32'h10);
        chk("irq held", 32'h1, {31'h0, irq});
        rc(OFF_INT_STATUS, 32'h4);
        wr(OFF_INT_STATUS, 32'h4);
        repeat (2) @(posedge sys_clk);
        chk("irq off", 32'h0, {31'h0, irq});
        chk("irq rises", 32'h1, {24'h0, irq_rises - rises0});
        wr(OFF_INT_ENABLE, 32'h0);
        $display("interrupt test done");
        ev(0);
        ev(1);
        rd(OFF_INT_STATUS);
        ev(0);
        wr(OFF_SNAP_EVENT, 32'h1);
        rc(OFF_SNAP_EVENT, 32'h2);
        rc(OFF_NEW_EVENT, 32'h1);
        wr(OFF_EVENT, 32'h1);
        rc(OFF_EVENT, 32'h2);
        wr(OFF_EVENT, 32'h2);
        rc(OFF_EVENT, 32'h0);
        wr(OFF_NEW_EVENT, 32'h5);
        rc(OFF_NEW_EVENT, 32'h5);
        wr(OFF_NEW_EVENT, 32'h1);
        rc(OFF_NEW_EVENT, 32'h1);
        wr(OFF_EVENT, 32'h1);
        $display("direct clear test done");
        wr(OFF_EVENT_ENABLE, 32'h07FFDFFF);
        ev(13);
        rc(OFF_INT_STATUS, 32'h0);
        wr(OFF_EVENT_ENABLE, 32'h07FFFFFF);
        rc(OFF_INT_STATUS, 32'h80);
        wr(OFF_EVENT, 32'h2000);
        for (int i = 0; i < 24; i++) begin
            ev(i);
            rc(OFF_INT_STATUS, 32'h1 << st_of[i]);
            wr(OFF_EVENT, 32'h1 << i);
        end
        $display("mapping test done");
        wr(OFF_INT_SET, 32'h400);
        rc(OFF_NEW_EVENT, 32'h001C0000);
        rc(OFF_INT_SET, 32'h0);
        wr(OFF_EVENT, 32'h001C0000);
        ev(21);
        fork
            wr(OFF_EVENT, 32'h00200000);
            begin
                // Pulse stands only in the cycle in which the clear lands
                repeat (2) @(posedge sys_clk);
                event_pulse[21] <= 1'b1;
                @(posedge sys_clk);
                event_pulse <= '0;
            end
        join
        rc(OFF_EVENT, 32'h00200000);
        fork
            rd(OFF_INT_STATUS);
            begin
                // Pulse stands only in the cycle of the snapshot
                @(posedge sys_clk);
                event_pulse[22] <= 1'b1;
                @(posedge sys_clk);
                event_pulse <= '0;
            end
        join
        rc(OFF_NEW_EVENT, 32'h00400000);
        rc(OFF_SNAP_EVENT, 32'h00200000);
        wr(OFF_EVENT, 32'h00600000);
        rc(OFF_EVENT, 32'h0);
        wr(8'h1C, 32'hFFFFFFFF);
        chk("bad write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        rd(8'h1C);
        chk("bad read resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("bad read data", 32'h0, d);
        $display("set and refusal test done");
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        print_verdict();
    end
endmodule // test_serial_bus_event_irq_logic

bind serial_bus_event_irq_logic serial_bus_event_irq_logic_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.*);
